//--- include/lbou_pkg.sv
// Shared constants and types of the logic and bit operations unit
package lbou_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DW      = 24;  // Data word width
  localparam int AMT_W   = 6;   // Shift amount and field width/offset
  localparam int BSEL_W  = 5;   // Bit selector of a bit test
  localparam int CSEL_W  = 3;   // Control register selector
  localparam int CNT_W   = 5;   // Leading bit count width

  // ----------------------------------------------------------------
  // Field specification layout
  // ----------------------------------------------------------------
  localparam int FLD_OFF_LSB = 0;   // Offset field position
  localparam int FLD_WID_LSB = 12;  // Width field position
  localparam int MERGE_HALF  = 12;  // Half-word size for the merge

  // ----------------------------------------------------------------
  // Condition code bit positions and reset value
  // ----------------------------------------------------------------
  localparam int CC_C = 0;  // Carry
  localparam int CC_V = 1;  // Overflow
  localparam int CC_Z = 2;  // Zero
  localparam int CC_N = 3;  // Negative
  localparam int CC_L = 6;  // Limit (sticky)
  localparam logic [7:0] CCR_RST = 8'h00;  // Flags after reset

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    op_and, op_bitwise_xor, op_or, op_not,
    op_logic_shift_left, op_logic_shift_right,
    op_rotate_left, op_rotate_right,
    op_shift_left_multi, op_shift_right_multi,
    op_extract_signed, op_field_extract_zero_ext, op_insert,
    op_merge, op_count_leading_bits,
    op_and_imm_to_ctrl, op_or_imm_to_ctrl,
    op_bit_test_only, op_bit_test_set, op_bit_test_clear,
    op_bit_test_change
  } lbou_op_t;

endpackage : lbou_pkg

//--- rtl/lbou_lead_cnt.sv
// Leading identical bit counter of the logic and bit operations unit
module lbou_lead_cnt
  import lbou_pkg::*;
#(
  parameter int W = DW  // Operand width
) (
  input  wire logic [W-1:0]     value,
  output logic      [CNT_W-1:0] count
);

  // ----------------------------------------------------------------
  // Count bits equal to the sign bit, below the sign bit itself
  // ----------------------------------------------------------------
  always_comb begin
    logic run;  // Still inside the leading run
    run   = 1'b1;
    count = '0;
    for (int i = W - 2; i >= 0; i--) begin
      // Stop at the first bit that differs from the sign
      if (run && (value[i] == value[W-1])) begin
        count = count + 5'h01;
      end else begin
        run = 1'b0;
      end
    end
  end

endmodule : lbou_lead_cnt

//--- rtl/lbou_unit.sv
// Logic and bit operations unit of the signal processor core
// Overview of operation
// - Every operation completes in one cycle
// - Bitwise results go to datapath registers
// - Immediate control forms write control register
// - Logical results update the condition flags
// - Concurrent move over memory or global bus
// - Concurrent move only with plain register forms
// - Multi-bit shifts, amount register or immediate
// - Field extract, signed and unsigned forms
// - Field insert, spec register or immediate
// - Merge two half words into one
// - Bit test reads one bit of memory
// - Bit left, set, cleared or inverted
// - Carry gets the bit before modification
// - Move keeps flags, limit set on saturation
module lbou_unit
  import lbou_pkg::*;
(
  input  wire logic              sys_clk,        // Core clock
  input  wire logic              rstn,           // Async reset, low
  input  wire logic              clk_en,         // Freezes state when low
  input  wire logic              issue_valid,    // Operation issued
  input  wire lbou_op_t          issue_op,       // Operation code
  input  wire logic              use_imm,        // Immediate form
  input  wire logic [DW-1:0]     dst_op,         // Destination register
  input  wire logic [DW-1:0]     src_op,         // Source register
  input  wire logic [DW-1:0]     spec_reg,       // Amount or field reg
  input  wire logic [DW-1:0]     imm_val,        // Immediate field
  input  wire logic [CSEL_W-1:0] ctrl_sel,       // Control reg select
  input  wire logic [DW-1:0]     ctrl_rd_data,   // Control reg value
  input  wire logic [DW-1:0]     mem_rd_data,    // Memory operand
  input  wire logic [BSEL_W-1:0] bit_sel,        // Tested bit number
  input  wire logic              pmove_req,      // Concurrent move asked
  input  wire logic              pmove_global,   // Global bus, else X/Y
  input  wire logic              pmove_limit,    // Move saturated a value
  output logic                   res_wr_r,       // Datapath reg write
  output logic      [DW-1:0]     res_data_r,     // Datapath result
  output logic                   ctrl_wr_r,      // Control reg write
  output logic      [CSEL_W-1:0] ctrl_wr_sel_r,  // Written control reg
  output logic      [DW-1:0]     ctrl_wr_data_r, // Control reg value
  output logic                   mem_wr_r,       // Memory write back
  output logic      [DW-1:0]     mem_wr_data_r,  // Modified memory word
  output logic                   pmove_go_r,     // Move granted
  output logic                   pmove_global_r, // Granted bus choice
  output logic                   pmove_refuse_r, // Move refused
  output logic      [7:0]        ccr_r           // Condition code reg
);
  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  logic [DW-1:0]    opnd_b;   // Second operand, reg or immediate
  logic [DW-1:0]    spec;     // Shift amount or field specification
  logic [AMT_W-1:0] amt;      // Shift amount
  logic [AMT_W-1:0] fwid;     // Field width
  logic [AMT_W-1:0] foff;     // Field offset
  logic [DW-1:0]    fmask;    // Field mask, low aligned
  logic [DW-1:0]    fraw;     // Extracted field, unsigned
  logic [CNT_W-1:0] lead_cnt; // Leading bit count
  logic             test_bit; // Selected memory bit before change
  assign opnd_b = use_imm ? imm_val : src_op;
  assign spec   = use_imm ? imm_val : spec_reg;
  assign amt    = spec[AMT_W-1:0];
  assign foff   = spec[FLD_OFF_LSB +: AMT_W];
  assign fwid   = spec[FLD_WID_LSB +: AMT_W];
  // Widths of 24 or more shift every one out, giving a full mask
  assign fmask  = ~(24'hFFFFFF << fwid);
  assign fraw   = (src_op >> foff) & fmask;
  assign test_bit = mem_rd_data[bit_sel];
  // Leading run length for the count operation
  lbou_lead_cnt #(.W(DW)) u_lead (.value(src_op), .count(lead_cnt));
  // ----------------------------------------------------------------
  // Result and carry computation
  // ----------------------------------------------------------------
  logic [DW-1:0] res_nxt;   // Datapath result
  logic          cry_nxt;   // Carry out
  logic          cry_upd;   // Operation loads carry
  logic          flg_upd;   // Operation loads N, Z and V
  logic          to_dp;     // Result goes to datapath register
  logic          to_ctrl;   // Result goes to control register
  logic          to_mem;    // Bit test writes memory back
  logic [DW-1:0] mem_nxt;   // Modified memory word
  always_comb begin
    res_nxt = '0;
    cry_nxt = ccr_r[CC_C];
    cry_upd = 1'b0;
    flg_upd = 1'b1;
    to_dp   = 1'b1;
    to_ctrl = 1'b0;
    to_mem  = 1'b0;
    mem_nxt = mem_rd_data;
    unique case (issue_op)
      // Plain bitwise forms run on datapath registers
      op_and:         res_nxt = dst_op & opnd_b;
      op_bitwise_xor: res_nxt = dst_op ^ opnd_b;
      op_or:          res_nxt = dst_op | opnd_b;
      op_not:         res_nxt = ~dst_op;
      op_logic_shift_left: begin
        res_nxt = {dst_op[DW-2:0], 1'b0};
        cry_nxt = dst_op[DW-1];
        cry_upd = 1'b1;
      end
      op_logic_shift_right: begin
        res_nxt = {1'b0, dst_op[DW-1:1]};
        cry_nxt = dst_op[0];
        cry_upd = 1'b1;
      end
      // Rotates go through the carry, not around the word
      op_rotate_left: begin
        res_nxt = {dst_op[DW-2:0], ccr_r[CC_C]};
        cry_nxt = dst_op[DW-1];
        cry_upd = 1'b1;
      end
      op_rotate_right: begin
        res_nxt = {ccr_r[CC_C], dst_op[DW-1:1]};
        cry_nxt = dst_op[0];
        cry_upd = 1'b1;
      end
      // Carry takes the last bit out; an amount of zero or above 24 keeps it
      op_shift_left_multi: begin
        res_nxt = dst_op << amt;
        if (amt != '0 && amt <= 6'(DW)) begin
          cry_nxt = dst_op[5'(6'(DW) - amt)];
          cry_upd = 1'b1;
        end
      end
      op_shift_right_multi: begin
        res_nxt = dst_op >> amt;
        if (amt != '0 && amt <= 6'(DW)) begin
          cry_nxt = dst_op[5'(amt - 6'h01)];
          cry_upd = 1'b1;
        end
      end
      op_extract_signed: begin
        res_nxt = fraw;
        // Sign extend only a field narrower than the word
        if (fwid != '0 && fwid < 6'(DW) && fraw[5'(fwid - 6'h01)]) begin
          res_nxt = fraw | ~fmask;
        end
      end
      op_field_extract_zero_ext: res_nxt = fraw;
      op_insert: begin
        res_nxt = (dst_op & ~(fmask << foff))
                | ((src_op & fmask) << foff);
      end
      op_merge: begin
        res_nxt = {src_op[MERGE_HALF-1:0],
                   dst_op[MERGE_HALF-1:0]};
      end
      op_count_leading_bits: res_nxt = DW'(lead_cnt);
      // Control forms bypass the datapath register file
      op_and_imm_to_ctrl, op_or_imm_to_ctrl: begin
        res_nxt = (issue_op == op_and_imm_to_ctrl)
                ? (ctrl_rd_data & imm_val)
                : (ctrl_rd_data | imm_val);
        to_dp   = 1'b0;
        to_ctrl = 1'b1;
        flg_upd = 1'b0;
      end
      // Bit tests load carry only and may write memory back
      op_bit_test_only, op_bit_test_set,
      op_bit_test_clear, op_bit_test_change: begin
        to_dp   = 1'b0;
        flg_upd = 1'b0;
        cry_nxt = test_bit;
        cry_upd = 1'b1;
        to_mem  = (issue_op != op_bit_test_only);
        mem_nxt[bit_sel] = (issue_op == op_bit_test_set) ? 1'b1
                         : (issue_op == op_bit_test_clear) ? 1'b0
                         : (issue_op == op_bit_test_change) ? ~test_bit
                         : test_bit;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // Concurrent move admission
  // ----------------------------------------------------------------
  logic mv_ok;  // Operation form allows a concurrent move
  // Immediate variants of the plain forms are refused as well
  assign mv_ok = !use_imm && (issue_op inside {op_and, op_bitwise_xor,
                  op_or, op_not, op_logic_shift_left, op_logic_shift_right,
                  op_rotate_left, op_rotate_right});
  // ----------------------------------------------------------------
  // Datapath result register, one cycle after issue
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      res_wr_r   <= 1'b0;
      res_data_r <= '0;
    end else if (clk_en) begin
      res_wr_r <= issue_valid && to_dp;
      // Data held between results to save toggling
      if (issue_valid && to_dp) begin
        res_data_r <= res_nxt;
      end
    end
  end
  // ----------------------------------------------------------------
  // Control register write back
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_wr_r      <= 1'b0;
      ctrl_wr_sel_r  <= '0;
      ctrl_wr_data_r <= '0;
    end else if (clk_en) begin
      ctrl_wr_r <= issue_valid && to_ctrl;
      if (issue_valid && to_ctrl) begin
        ctrl_wr_sel_r  <= ctrl_sel;
        ctrl_wr_data_r <= res_nxt;
      end
    end
  end
  // ----------------------------------------------------------------
  // Memory write back of bit tests
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_wr_r      <= 1'b0;
      mem_wr_data_r <= '0;
    end else if (clk_en) begin
      mem_wr_r <= issue_valid && to_mem;
      if (issue_valid && to_mem) begin
        mem_wr_data_r <= mem_nxt;
      end
    end
  end
  // ----------------------------------------------------------------
  // Concurrent move grant
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pmove_go_r     <= 1'b0;
      pmove_global_r <= 1'b0;
      pmove_refuse_r <= 1'b0;
    end else if (clk_en) begin
      pmove_go_r     <= issue_valid && pmove_req && mv_ok;
      pmove_refuse_r <= issue_valid && pmove_req && !mv_ok;
      pmove_global_r <= pmove_global;
    end
  end
  // ----------------------------------------------------------------
  // Condition code register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ccr_r <= CCR_RST;
    end else if (clk_en && issue_valid) begin
      if (flg_upd) begin
        ccr_r[CC_N] <= res_nxt[DW-1];
        ccr_r[CC_Z] <= (res_nxt == '0);
        ccr_r[CC_V] <= 1'b0;
      end
      if (cry_upd) begin
        ccr_r[CC_C] <= cry_nxt;
      end
      // The move itself touches only the sticky limit flag
      if (pmove_req && mv_ok && pmove_limit) begin
        ccr_r[CC_L] <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic go;  // Issue taken this cycle
  assign go = clk_en && issue_valid;
  one_cycle_a: assert property (go && to_dp |=> res_wr_r)
    else $error("datapath result late");
  back_to_back_a: assert property (
    go && to_dp ##1 go && to_dp |=> res_wr_r)
    else $error("second result missing");
  ctrl_dest_a: assert property (go && to_ctrl |=> ctrl_wr_r && !res_wr_r
    && ctrl_wr_data_r == $past(res_nxt))
    else $error("control form wrote wrong place");
  zero_flag_a: assert property (go && flg_upd |=>
    ccr_r[CC_Z] == (res_data_r == '0))
    else $error("zero flag mismatch");
  move_refuse_a: assert property (go && pmove_req && use_imm |=>
    pmove_refuse_r && !pmove_go_r)
    else $error("immediate form took a move");
  test_carry_a: assert property (go && to_mem |=>
    ccr_r[CC_C] == $past(test_bit) && mem_wr_r)
    else $error("bit test carry wrong");
  test_only_a: assert property (
    go && issue_op == op_bit_test_only |=> !mem_wr_r)
    else $error("test only wrote memory");
  move_limit_a: assert property (go && pmove_req && mv_ok
    && pmove_limit |=> ccr_r[CC_L])
    else $error("limit flag not set");
  rotate_fill_a: assert property (go && issue_op == op_rotate_left
    |=> res_data_r[0] == $past(ccr_r[CC_C]))
    else $error("rotate fill wrong");
  rotate_seen_c: cover property (go && issue_op == op_rotate_right);
  move_seen_c:   cover property (go && pmove_req && mv_ok);
  insert_seen_c: cover property (go && issue_op == op_insert);
  change_seen_c: cover property (go && issue_op == op_bit_test_change);
endmodule : lbou_unit

//--- test/lbou_partner.sv
// Control registers and data memory that face the unit
module lbou_partner
  import lbou_pkg::*;
(
  input  wire logic              sys_clk,  // Core clock
  input  wire logic              rstn,     // Async reset, low
  input  wire logic              clk_en,   // State advances when high
  input  wire logic [3:0]        mem_addr, // Word under bit test
  input  wire logic [CSEL_W-1:0] ctrl_sel, // Control reg read select
  input  wire logic              ctrl_wr,  // Control reg write
  input  wire logic [CSEL_W-1:0] wr_sel,   // Written control reg
  input  wire logic [DW-1:0]     ctrl_wd,  // Written control value
  input  wire logic              mem_wr,   // Memory write back
  input  wire logic [DW-1:0]     mem_wd,   // Written memory word
  output logic      [DW-1:0]     ctrl_rd,  // Selected control reg
  output logic      [DW-1:0]     mem_rd    // Addressed memory word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DW-1:0] creg_r [8];  // Control registers
  logic [DW-1:0] mem_r  [16]; // Data memory words
  logic [3:0]    addr_r;      // Address of the issued bit test

  // --------------------------------------------------------------
  // Reads are combinational, as the core's register paths are
  // --------------------------------------------------------------
  assign ctrl_rd = creg_r[ctrl_sel];
  assign mem_rd  = mem_r[mem_addr];

  // Write back lands one enabled cycle after issue, at its address
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) begin
        mem_r[i] <= 24'h5A0000 ^ 24'(i * 24'h111);
      end
      for (int i = 0; i < 8; i++) begin
        creg_r[i] <= 24'(i * 24'h10101);
      end
    end else if (clk_en) begin
      addr_r <= mem_addr;
      if (ctrl_wr) begin
        creg_r[wr_sel] <= ctrl_wd;
      end
      if (mem_wr) begin
        mem_r[addr_r] <= mem_wd;
      end
    end
  end
endmodule : lbou_partner

//--- test/lbou_unit_tb.sv
// Self-checking bench of the logic and bit operations unit
module lbou_unit_tb
  import lbou_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------
  // Design ports and model state
  // --------------------------------------------------------------
  logic sys_clk, rstn, clk_en, issue_valid, use_imm;
  logic pmove_req, pmove_global, pmove_limit;
  lbou_op_t          issue_op;
  logic [DW-1:0]     dst_op, src_op, spec_reg, imm_val;
  logic [DW-1:0]     ctrl_rd_data, mem_rd_data;
  logic [CSEL_W-1:0] ctrl_sel, ctrl_wr_sel_r, e_cs;
  logic [BSEL_W-1:0] bit_sel;
  logic [3:0]        mem_addr;     // Partner memory word
  logic res_wr_r, ctrl_wr_r, mem_wr_r;
  logic pmove_go_r, pmove_global_r, pmove_refuse_r;
  logic [DW-1:0]     res_data_r, ctrl_wr_data_r, mem_wr_data_r;
  logic [7:0]        ccr_r, e_ccr; // Flags, design and model
  logic e_res, e_ctrl, e_mem, e_mdc, e_go, e_ref, e_gl; // Model pulses
  logic [DW-1:0]     e_rd, e_cd, e_md;  // Model data words
  logic [31:0]       seed = 32'hEF55;   // Random generator state
  int                error_cnt = 0;
  int                comparisons = 0;

  lbou_unit dut (
    .sys_clk, .rstn, .clk_en, .issue_valid, .issue_op, .use_imm,
    .dst_op, .src_op, .spec_reg, .imm_val, .ctrl_sel, .ctrl_rd_data,
    .mem_rd_data, .bit_sel, .pmove_req, .pmove_global, .pmove_limit,
    .res_wr_r, .res_data_r, .ctrl_wr_r, .ctrl_wr_sel_r, .ctrl_wr_data_r,
    .mem_wr_r, .mem_wr_data_r, .pmove_go_r, .pmove_global_r,
    .pmove_refuse_r, .ccr_r
  );
  lbou_partner partner (
    .sys_clk, .rstn, .clk_en, .mem_addr, .ctrl_sel,
    .ctrl_wr(ctrl_wr_r), .wr_sel(ctrl_wr_sel_r), .ctrl_wd(ctrl_wr_data_r),
    .mem_wr(mem_wr_r), .mem_wd(mem_wr_data_r),
    .ctrl_rd(ctrl_rd_data), .mem_rd(mem_rd_data)
  );

  always #20 sys_clk = ~sys_clk;

  // --------------------------------------------------------------
  // Random values and comparisons
  // --------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // Field spec that stays inside the word
  function automatic logic [DW-1:0] fspec();
    logic [DW-1:0] v;
    int o;
    v = 24'(rnd());
    o = int'(rnd() % 24);
    v[5:0] = 6'(o);
    v[17:12] = 6'(rnd() % (25 - o));
    return v;
  endfunction : fspec

  task automatic report(logic [DW-1:0] got, logic [DW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : report
  task automatic cmp_word(logic [DW-1:0] got, logic [DW-1:0] exp);
    report(got, exp);
  endtask : cmp_word
  task automatic cmp_flags(logic [7:0] got, logic [7:0] exp);
    report(24'(got), 24'(exp));
  endtask : cmp_flags
  task automatic cmp_bit(logic got, logic exp);
    report(24'(got), 24'(exp));
  endtask : cmp_bit

  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // --------------------------------------------------------------
  // Model of one enabled edge, from the rules
  // --------------------------------------------------------------
  task automatic clear_model();
    {e_res, e_ctrl, e_mem, e_mdc, e_go, e_ref, e_gl} = '0;
    e_ccr = CCR_RST;
  endtask : clear_model

  task automatic predict();
    logic [DW-1:0] a, r, m;
    logic c;
    int n, w;
    if (!clk_en) return; // Frozen edge keeps every output
    {e_res, e_ctrl, e_mem, e_mdc, e_go, e_ref} = '0;
    if (!issue_valid) return;
    a = dst_op;
    r = use_imm ? imm_val : src_op;
    m = use_imm ? imm_val : spec_reg;
    n = int'(m[5:0]);
    w = int'(m[17:12]);
    m = (w >= 24) ? 24'hFFFFFF : (24'h1 << w) - 24'h1;
    c = e_ccr[CC_C];
    e_res = 1'b1;
    case (issue_op)
      op_and:               r = a & r;
      op_bitwise_xor:       r = a ^ r;
      op_or:                r = a | r;
      op_not:               r = ~a;
      op_logic_shift_left:  {c, r} = {a, 1'b0};
      op_logic_shift_right: {r, c} = {1'b0, a};
      op_rotate_left:       {c, r} = {a, c};
      op_rotate_right:      {r, c} = {c, a};
      op_shift_left_multi: begin
        if (n >= 1 && n <= 24) c = a[24 - n];
        r = a << n;
      end
      op_shift_right_multi: begin
        if (n >= 1 && n <= 24) c = a[n - 1];
        r = a >> n;
      end
      op_insert: r = (a & ~(m << n)) | ((src_op & m) << n);
      op_merge:  r = {src_op[11:0], dst_op[11:0]};
      op_count_leading_bits: begin
        r = '0;
        for (int i = 22; i >= 0 && src_op[i] == src_op[23]; i--) r++;
      end
      op_extract_signed, op_field_extract_zero_ext: begin
        r = (src_op >> n) & m;
        if (issue_op == op_extract_signed && w > 0 && r[w - 1]) r |= ~m;
      end
      op_and_imm_to_ctrl, op_or_imm_to_ctrl: begin
        {e_res, e_ctrl} = 2'b01;
        e_cs = ctrl_sel;
        e_cd = (issue_op == op_and_imm_to_ctrl) ?
               (ctrl_rd_data & imm_val) : (ctrl_rd_data | imm_val);
      end
      default: begin
        // Test-only may or may not write back its unchanged word
        e_res = 1'b0;
        e_mdc = (issue_op == op_bit_test_only);
        e_mem = !e_mdc;
        e_md = mem_rd_data;
        e_ccr[CC_C] = mem_rd_data[bit_sel];
        if (issue_op == op_bit_test_set) e_md[bit_sel] = 1'b1;
        if (issue_op == op_bit_test_clear) e_md[bit_sel] = 1'b0;
        if (issue_op == op_bit_test_change) e_md[bit_sel] ^= 1'b1;
      end
    endcase
    if (e_res) begin
      e_rd = r;
      e_ccr[CC_C] = c;
      e_ccr[CC_V] = 1'b0;
      e_ccr[CC_Z] = (r == '0);
      e_ccr[CC_N] = r[DW-1];
    end
    if (pmove_req) begin
      e_go = !use_imm && issue_op <= op_rotate_right;
      e_ref = !e_go;
      e_gl = pmove_global;
      if (e_go && pmove_limit) e_ccr[CC_L] = 1'b1;
    end
  endtask : predict

  task automatic check();
    cmp_bit(res_wr_r, e_res);
    cmp_bit(ctrl_wr_r, e_ctrl);
    cmp_bit(pmove_go_r, e_go);
    cmp_bit(pmove_refuse_r, e_ref);
    cmp_flags(ccr_r, e_ccr);
    if (!e_mdc) cmp_bit(mem_wr_r, e_mem);
    if (e_res) cmp_word(res_data_r, e_rd);
    if (e_ctrl) cmp_word(ctrl_wr_data_r, e_cd);
    if (e_ctrl) cmp_word(24'(ctrl_wr_sel_r), 24'(e_cs));
    if (e_go) cmp_bit(pmove_global_r, e_gl);
    if (e_mem || (e_mdc && mem_wr_r === 1'b1))
      cmp_word(mem_wr_data_r, e_md);
  endtask : check

  // --------------------------------------------------------------
  // Stimulus: every op four times with a move, then random traffic
  // --------------------------------------------------------------
  task automatic stim(int k);
    logic [31:0] x;
    bit d;
    d = (k < 84);
    x = rnd();
    clk_en = d || x[2:0] != 3'h0;
    issue_valid = d || x[3];
    issue_op = lbou_op_t'(5'(d ? k % 21 : int'(rnd() % 21)));
    use_imm = x[5] && (issue_op <= op_or ||
              (issue_op >= op_shift_left_multi && issue_op <= op_insert));
    pmove_req = d || x[4];
    {pmove_global, pmove_limit} = x[7:6];
    dst_op = 24'(rnd());
    src_op = 24'(rnd());
    imm_val = 24'(rnd());
    spec_reg = fspec();
    if (issue_op >= op_shift_left_multi && issue_op <= op_insert)
      imm_val = fspec();
    if (issue_op inside {op_shift_left_multi, op_shift_right_multi}) begin
      spec_reg[5:0] = 6'(rnd() % 26);
      imm_val[5:0] = 6'(rnd() % 26);
    end
    ctrl_sel = 3'(rnd());
    mem_addr = 4'(rnd());
    bit_sel = 5'(rnd() % 24);
  endtask : stim

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    {clk_en, issue_valid, use_imm, pmove_req, pmove_global} = '0;
    pmove_limit = 1'b0;
    issue_op = op_and;
    {dst_op, src_op, spec_reg, imm_val} = '0;
    {ctrl_sel, bit_sel, mem_addr} = '0;
    clear_model();
    repeat (5) @(posedge sys_clk);
    #1;
    check();
    rstn = 1'b1;
    for (int k = 0; k < 3000; k++) begin
      if (k == 1500) begin
        // Second reset in mid-run clears flags and pulses
        rstn = 1'b0;
        clear_model();
        #1;
        check();
        @(posedge sys_clk);
        #1;
        rstn = 1'b1;
      end
      stim(k);
      #1; // Let the partner's read paths settle first
      predict();
      @(posedge sys_clk);
      #1;
      check();
    end
    conclude();
  end
endmodule : lbou_unit_tb
